// File: rtl/pec_pkg.sv
/*
 * Package for the pin-electronics control register bank: register
 * addresses, field positions, reset values, enumerations and carriers.
 * Assumes a single 100 MHz clock domain on the register side.
 */
package pec_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int NUM_CH = 2;

    // Register addresses
    localparam logic [4:0] ADDR_PIN_ENABLE = 5'h0C;
    localparam logic [4:0] ADDR_CH_STATE = 5'h0D;
    localparam logic [4:0] ADDR_MEASURE_UNIT_STATE = 5'h0E;
    localparam logic [4:0] ADDR_MEAS_OUT = 5'h0F;
    localparam logic [4:0] ADDR_DIFF_CMP = 5'h10;
    localparam logic [4:0] ADDR_DAC_MON = 5'h11;
    localparam logic [4:0] ADDR_ALM_MASK = 5'h12;
    localparam logic [4:0] ADDR_ALM_STATE = 5'h13;

    // Register widths
    localparam int W_PIN_ENABLE = 3;
    localparam int W_CH_STATE = 3;
    localparam int W_MEASURE_UNIT_STATE = 10;
    localparam int W_MEAS_OUT = 3;
    localparam int W_DAC_MON = 2;
    localparam int W_ALM_MASK = 2;
    localparam int W_ALM_STATE = 3;

    // Field positions
    localparam int PE_DRV_DISABLE = 0;
    localparam int PE_FORCE_TERM = 1;
    localparam int PIN_ENABLE_CONTROL = 2;
    localparam int CS_DRV_TERM = 0;
    localparam int CS_LOAD_EN = 1;
    localparam int CS_HV_EN = 2;
    localparam int PS_RANGE_LSB = 0;
    localparam int PS_FORCE_I = 3;
    localparam int PS_MEAS_I = 4;
    localparam int PS_CLAMP_EN = 5;
    localparam int PS_SENSE_EXT = 7;
    localparam int PS_SRC_LSB = 8;
    localparam int MO_OE = 0;
    localparam int MO_SEL_LSB = 1;
    localparam int DM_SEL = 0;
    localparam int DM_EN = 1;
    localparam int AM_OVD = 0;
    localparam int AM_PMU = 1;
    localparam int AS_OVD_LO = 0;
    localparam int AS_OVD_HI = 1;
    localparam int AS_CLAMP = 2;

    // Reset values
    localparam logic [2:0] RST_PIN_ENABLE = 3'h0;
    localparam logic [2:0] RST_CH_STATE = 3'h0;
    localparam logic [9:0] RST_MEASURE_UNIT_STATE = 10'h000;
    localparam logic [2:0] RST_MEAS_OUT = 3'h0;
    localparam logic RST_DIFF_CMP = 1'h0;
    localparam logic [1:0] RST_DAC_MON = 2'h0;
    localparam logic [1:0] RST_ALM_MASK = 2'h1;
    localparam logic [2:0] RST_ALM_SYNC = 3'h0;

    // Bit 6 of the measure unit state is reserved and never stored
    localparam logic [9:0] MEASURE_UNIT_STATE_WMASK = 10'h3BF;

    typedef enum logic [1:0] {
        PEC_SRC_GND,
        PEC_SRC_GND_2V5,
        PEC_SRC_DAC
    } pec_src_e;

    typedef enum logic [2:0] {
        PEC_RANGE_E,
        PEC_RANGE_D,
        PEC_RANGE_C,
        PEC_RANGE_B,
        PEC_RANGE_A
    } pec_range_e;

    typedef enum logic [1:0] {
        PEC_ROUTE_CH0,
        PEC_ROUTE_CH1,
        PEC_ROUTE_TEMP_GND,
        PEC_ROUTE_TEMP
    } pec_route_e;

    typedef struct packed {
        logic drv_disable;
        logic force_term;
        logic load_en;
        logic drv_term_mode;
        logic pmu_force_en;
        logic pmu_clamp_en;
        logic pmu_force_i;
        logic pmu_meas_i;
        logic pmu_sense_ext;
        pec_src_e pmu_src;
        pec_range_e pmu_range;
    } pec_chan_ctrl_s;

    typedef struct packed {
        logic clamp;
        logic ovd_hi;
        logic ovd_lo;
    } pec_alarm_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] ch_sel;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pec_reg_req_s;

endpackage

// File: rtl/pec_regs.sv
/*
 * Control and status register bank of a dual-channel pin-electronics
 * device, with the decoded per-channel and shared control outputs.
 * Assumes the serial word has already been deframed upstream into a
 * one-cycle request on i_clk; analog status levels arrive asynchronously.
 */
// Functional notes
// R01: Measure unit enable 0 disables force and clamps, forces measure-voltage.
// R02: With unit disabled, state fields ignored except the sense path bit.
// R03: Force-termination bit 1 drives pin to termination level.
// R04: Driver disable bit 1 shuts driver into low leakage, 0 enables it.
// R05: High-voltage select 0 keeps output low impedance, 1 enables it.
// R06: High-voltage bit acts on channel 0 only; channel 1 select ignored.
// R07: Load enable bit switches active load; driver mode picks high-Z or termination.
// R08: Input selection 00 ground, 01 ground plus 2.5 V, 1x precision DAC.
// R09: Force mode picks voltage or current; clamp bit enables clamps.
// R10: Measure mode picks voltage or current; sense bit internal or external.
// R11: Range code 0xx is range E; 100 to 111 are ranges D to A.
// R12: Output select routes channel 0, channel 1, sensor ground, sensor.
// R13: Measurement output enable 0 tristates the shared output.
// R14: Shared registers accessed when either channel select bit is set.
// R15: Differential enable puts differential comparator outputs on channel 0.
// R16: Monitor enable bit tristates or enables the DAC monitor output.
// R17: Monitor select routes channel 0 or channel 1 precision DAC.
// R18: Mask bits enable the measure unit and overvoltage alarm flags.
// R19: Clamp flag reads 1 while the measure unit is clamped.
// R20: High overvoltage flag reads 1 above the high threshold.
// R21: Low overvoltage flag reads 1 below the low threshold.
// R22: Alarm state register is read only.
// R23: Narrow registers read back zero-filled to sixteen bits.
// R24: Select 00 changes nothing; 01 channel 0, 10 channel 1, 11 both.
// R25: Reserved state bit 6 has no effect and reads zero.
`timescale 1ns/100ps
module pec_regs (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register request and read answer
    input wire pec_pkg::pec_reg_req_s i_req,
    output logic [15:0] o_rdata,
    output logic o_rd_valid,
    // Analog status levels, asynchronous
    input wire pec_pkg::pec_alarm_s [1:0] i_alarm_lvl,
    // Per-channel decoded controls
    output pec_pkg::pec_chan_ctrl_s [1:0] o_chan,
    output logic o_hv_out_en,
    // Shared controls
    output pec_pkg::pec_route_e o_meas_route,
    output logic o_meas_oe,
    output logic o_diff_cmp_en,
    output logic o_dac_mon_en,
    output logic o_dac_mon_sel,
    // Masked alarm flags
    output logic [1:0] o_pmu_alarm,
    output logic [1:0] o_ovd_alarm
);
    import pec_pkg::*;

    // Request decode
    wire any_sel = |i_req.ch_sel;
    wire hit_pe = i_req.addr == ADDR_PIN_ENABLE;
    wire hit_cs = i_req.addr == ADDR_CH_STATE;
    wire hit_ps = i_req.addr == ADDR_MEASURE_UNIT_STATE;
    wire hit_mo = i_req.addr == ADDR_MEAS_OUT;
    wire hit_dc = i_req.addr == ADDR_DIFF_CMP;
    wire hit_dm = i_req.addr == ADDR_DAC_MON;
    wire hit_am = i_req.addr == ADDR_ALM_MASK;
    wire hit_as = i_req.addr == ADDR_ALM_STATE;
    // Shared registers respond to any non-zero channel select
    wire wr_shared = i_req.wr && any_sel; // [R14] [R24]
    wire wr_mo = wr_shared && hit_mo;
    wire wr_dc = wr_shared && hit_dc;
    wire wr_dm = wr_shared && hit_dm;
    // The high-voltage bit follows the channel 0 select only
    wire wr_hv = i_req.wr && i_req.ch_sel[0] && hit_cs; // [R06]

    // Shared registers
    logic [2:0] meas_out_r;
    logic diff_cmp_r;
    logic [1:0] dac_mon_r;
    logic hv_en_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meas_out_r <= RST_MEAS_OUT;
            diff_cmp_r <= RST_DIFF_CMP;
            dac_mon_r <= RST_DAC_MON;
            hv_en_r <= RST_CH_STATE[CS_HV_EN];
        end else begin
            if (wr_mo) begin
                meas_out_r <= i_req.wdata[W_MEAS_OUT-1:0];
            end
            if (wr_dc) begin
                diff_cmp_r <= i_req.wdata[0];
            end
            if (wr_dm) begin
                dac_mon_r <= i_req.wdata[W_DAC_MON-1:0];
            end
            if (wr_hv) begin
                hv_en_r <= i_req.wdata[CS_HV_EN];
            end
        end
    end

    assign o_meas_route = pec_route_e'(meas_out_r[MO_SEL_LSB +: 2]); // [R12]
    assign o_meas_oe = meas_out_r[MO_OE]; // [R13]
    assign o_diff_cmp_en = diff_cmp_r; // [R15]
    assign o_dac_mon_en = dac_mon_r[DM_EN]; // [R16]
    assign o_dac_mon_sel = dac_mon_r[DM_SEL]; // [R17]
    assign o_hv_out_en = hv_en_r; // [R05]

    // Per-channel registers, read values and controls
    logic [15:0] rd_ch [NUM_CH];

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            wire sel = i_req.ch_sel[ch]; // [R24]
            wire wr_pe = i_req.wr && sel && hit_pe;
            wire wr_cs = i_req.wr && sel && hit_cs;
            wire wr_ps = i_req.wr && sel && hit_ps;
            wire wr_am = i_req.wr && sel && hit_am;

            logic [2:0] pin_en_r;
            logic [1:0] ch_state_r;
            logic [9:0] measure_unit_state_r;
            logic [1:0] alm_mask_r;
            logic [2:0] sync1_r;
            logic [2:0] sync2_r;
            logic [2:0] sync3_r;
            logic [2:0] alm_r;
            pec_chan_ctrl_s ctrl_nxt;
            pec_chan_ctrl_s ctrl_r;
            logic pmu_alm_r;
            logic ovd_alm_r;

            wire [2:0] alm_raw = {i_alarm_lvl[ch].clamp, i_alarm_lvl[ch].ovd_hi,
                                  i_alarm_lvl[ch].ovd_lo};
            // A level counts once the second and third stages agree
            wire [2:0] agree = ~(sync2_r ^ sync3_r);
            wire [2:0] alm_nxt = (agree & sync3_r) | (~agree & alm_r);
            wire pmu_on = pin_en_r[PIN_ENABLE_CONTROL];
            wire [2:0] rng = measure_unit_state_r[PS_RANGE_LSB +: 3];
            wire [1:0] src = measure_unit_state_r[PS_SRC_LSB +: 2];
            wire hv_rd = (ch == 0) ? hv_en_r : 1'b0;

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pin_en_r <= RST_PIN_ENABLE;
                    ch_state_r <= RST_CH_STATE[1:0];
                    measure_unit_state_r <= RST_MEASURE_UNIT_STATE;
                    alm_mask_r <= RST_ALM_MASK;
                end else begin
                    if (wr_pe) begin
                        pin_en_r <= i_req.wdata[W_PIN_ENABLE-1:0];
                    end
                    if (wr_cs) begin
                        ch_state_r <= i_req.wdata[1:0];
                    end
                    if (wr_ps) begin
                        // Reserved bit is dropped here so it reads zero
                        measure_unit_state_r <= i_req.wdata[9:0] & MEASURE_UNIT_STATE_WMASK; // [R25]
                    end
                    if (wr_am) begin
                        alm_mask_r <= i_req.wdata[W_ALM_MASK-1:0];
                    end
                end
            end

            // Status synchroniser; the state register has no write path
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    sync1_r <= RST_ALM_SYNC;
                    sync2_r <= RST_ALM_SYNC;
                    sync3_r <= RST_ALM_SYNC;
                    alm_r <= RST_ALM_SYNC;
                end else begin
                    sync1_r <= alm_raw;
                    sync2_r <= sync1_r;
                    sync3_r <= sync2_r;
                    alm_r <= alm_nxt; // [R19] [R20] [R21] [R22]
                end
            end

            // Control decode
            always_comb begin
                ctrl_nxt = '0;
                ctrl_nxt.drv_disable = pin_en_r[PE_DRV_DISABLE]; // [R04]
                ctrl_nxt.force_term = pin_en_r[PE_FORCE_TERM]; // [R03]
                ctrl_nxt.load_en = ch_state_r[CS_LOAD_EN]; // [R07]
                ctrl_nxt.drv_term_mode = ch_state_r[CS_DRV_TERM]; // [R07]
                // Sense path stays live even with the unit disabled
                ctrl_nxt.pmu_sense_ext = measure_unit_state_r[PS_SENSE_EXT]; // [R02] [R10]
                ctrl_nxt.pmu_src = PEC_SRC_GND;
                ctrl_nxt.pmu_range = PEC_RANGE_E;
                ctrl_nxt.pmu_force_en = pmu_on; // [R01]
                if (pmu_on) begin
                    ctrl_nxt.pmu_clamp_en = measure_unit_state_r[PS_CLAMP_EN]; // [R09]
                    ctrl_nxt.pmu_force_i = measure_unit_state_r[PS_FORCE_I]; // [R09]
                    ctrl_nxt.pmu_meas_i = measure_unit_state_r[PS_MEAS_I]; // [R10]
                    case (src)
                        2'h0: ctrl_nxt.pmu_src = PEC_SRC_GND; // [R08]
                        2'h1: ctrl_nxt.pmu_src = PEC_SRC_GND_2V5;
                        default: ctrl_nxt.pmu_src = PEC_SRC_DAC;
                    endcase
                    case (rng)
                        3'h4: ctrl_nxt.pmu_range = PEC_RANGE_D; // [R11]
                        3'h5: ctrl_nxt.pmu_range = PEC_RANGE_C;
                        3'h6: ctrl_nxt.pmu_range = PEC_RANGE_B;
                        3'h7: ctrl_nxt.pmu_range = PEC_RANGE_A;
                        default: ctrl_nxt.pmu_range = PEC_RANGE_E;
                    endcase
                end
            end

            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    ctrl_r <= '0;
                    pmu_alm_r <= 1'b0;
                    ovd_alm_r <= 1'b0;
                end else begin
                    ctrl_r <= ctrl_nxt;
                    pmu_alm_r <= alm_mask_r[AM_PMU] & alm_r[AS_CLAMP]; // [R18]
                    ovd_alm_r <= alm_mask_r[AM_OVD] & (alm_r[AS_OVD_HI] | alm_r[AS_OVD_LO]);
                end
            end

            assign o_chan[ch] = ctrl_r;
            assign o_pmu_alarm[ch] = pmu_alm_r;
            assign o_ovd_alarm[ch] = ovd_alm_r;

            // Read values, upper bits zero-filled
            assign rd_ch[ch] =
                hit_pe ? {13'h0000, pin_en_r} : // [R23]
                hit_cs ? {13'h0000, hv_rd, ch_state_r} :
                hit_ps ? {6'h00, measure_unit_state_r} :
                hit_am ? {14'h0000, alm_mask_r} :
                hit_as ? {13'h0000, alm_r} : 16'h0000;
        end
    endgenerate

    // Read path: channel 0 answers when both selects are set
    wire hit_shared = hit_mo || hit_dc || hit_dm;
    wire [15:0] rd_shared = hit_mo ? {13'h0000, meas_out_r} :
                            hit_dc ? {15'h0000, diff_cmp_r} :
                            hit_dm ? {14'h0000, dac_mon_r} : 16'h0000;
    wire [15:0] rd_sel = !any_sel ? 16'h0000 :
                         hit_shared ? rd_shared : // [R14]
                         i_req.ch_sel[0] ? rd_ch[0] : rd_ch[1];

    logic [15:0] rdata_r;
    logic rd_valid_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= 16'h0000;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= i_req.rd;
            if (i_req.rd) begin
                rdata_r <= rd_sel;
            end
        end
    end

    assign o_rdata = rdata_r;
    assign o_rd_valid = rd_valid_r;

endmodule

// File: test/pec_regs_monitor.sv
/*
 * Concurrent checks on the ports of the pin-electronics register bank.
 * Assumes it is bound to pec_regs and sees only that module's ports.
 */
`timescale 1ns/100ps
module pec_regs_monitor (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire pec_pkg::pec_reg_req_s i_req,
    input wire logic [15:0] o_rdata,
    input wire logic o_rd_valid,
    input wire pec_pkg::pec_alarm_s [1:0] i_alarm_lvl,
    input wire pec_pkg::pec_chan_ctrl_s [1:0] o_chan,
    input wire logic o_hv_out_en,
    input wire pec_pkg::pec_route_e o_meas_route,
    input wire logic o_meas_oe,
    input wire logic o_diff_cmp_en,
    input wire logic o_dac_mon_en,
    input wire logic o_dac_mon_sel,
    input wire logic [1:0] o_pmu_alarm,
    input wire logic [1:0] o_ovd_alarm
);
    import pec_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_shared_wr(logic [4:0] adr);
        i_req.wr && i_req.addr == adr && i_req.ch_sel != 2'b00;
    endsequence
    sequence s_pe_wr0;
        i_req.wr && i_req.addr == ADDR_PIN_ENABLE && i_req.ch_sel[0];
    endsequence

    chk_pe_decode: assert property (s_pe_wr0 |-> ##2
        {o_chan[0].force_term, o_chan[0].drv_disable} == $past(i_req.wdata[1:0], 2))
        else $error("driver controls do not follow enable write");
    chk_unit_off: assert property (!o_chan[0].pmu_force_en |->
        !o_chan[0].pmu_clamp_en && !o_chan[0].pmu_meas_i)
        else $error("disabled unit still clamps or measures current");
    chk_unit_off_src: assert property (!o_chan[1].pmu_force_en |->
        o_chan[1].pmu_src == PEC_SRC_GND && o_chan[1].pmu_range == PEC_RANGE_E)
        else $error("disabled unit still uses state fields");
    chk_rd_zero_fill: assert property (i_req.rd |=> o_rd_valid && o_rdata[15:10] == 6'h00)
        else $error("read answer missing or upper bits set");
    chk_nop_read: assert property (i_req.rd && i_req.ch_sel == 2'b00
        |=> o_rdata == 16'h0000)
        else $error("read without channel returned data");
    chk_hv_write: assert property (i_req.wr && i_req.ch_sel[0]
        && i_req.addr == ADDR_CH_STATE |=> o_hv_out_en == $past(i_req.wdata[2]))
        else $error("high voltage enable not written");
    chk_hv_ch1_only: assert property (i_req.wr && i_req.addr == ADDR_CH_STATE
        && i_req.ch_sel == 2'b10 |=> $stable(o_hv_out_en))
        else $error("channel 1 write changed high voltage enable");
    chk_meas_out: assert property (s_shared_wr(ADDR_MEAS_OUT) |=>
        {o_meas_route, o_meas_oe} == $past(i_req.wdata[2:0]))
        else $error("measure output controls not written");
    chk_dac_mon: assert property (s_shared_wr(ADDR_DAC_MON) |=>
        {o_dac_mon_en, o_dac_mon_sel} == $past(i_req.wdata[1:0]))
        else $error("monitor controls not written");
    chk_pmu_alarm_low: assert property ((!i_alarm_lvl[0].clamp) [*7] |-> !o_pmu_alarm[0])
        else $error("clamp alarm without clamp");
    chk_ovd_alarm_low: assert property (
        (!i_alarm_lvl[1].ovd_hi && !i_alarm_lvl[1].ovd_lo) [*7] |-> !o_ovd_alarm[1])
        else $error("overvoltage alarm without overvoltage");
endmodule

bind pec_regs pec_regs_monitor pec_regs_monitor_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_req(i_req), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .i_alarm_lvl(i_alarm_lvl),
    .o_chan(o_chan), .o_hv_out_en(o_hv_out_en), .o_meas_route(o_meas_route),
    .o_meas_oe(o_meas_oe), .o_diff_cmp_en(o_diff_cmp_en), .o_dac_mon_en(o_dac_mon_en),
    .o_dac_mon_sel(o_dac_mon_sel), .o_pmu_alarm(o_pmu_alarm), .o_ovd_alarm(o_ovd_alarm));

// File: test/pec_regs_tb.sv
/*
 * Self-checking bench for the pin-electronics register bank.
 * Assumes the bank answers reads one cycle after the strobe edge.
 */
`timescale 1ns/100ps
module pec_regs_tb;
    import pec_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    pec_reg_req_s req = '0;
    pec_alarm_s [1:0] alm = '0;
    pec_chan_ctrl_s [1:0] o_chan;
    pec_route_e o_meas_route;
    logic [15:0] o_rdata;
    logic o_rd_valid, o_hv_out_en, o_meas_oe, o_diff_cmp_en, o_dac_mon_en, o_dac_mon_sel;
    logic [1:0] o_pmu_alarm, o_ovd_alarm, rch;
    logic [4:0] radr;
    logic [15:0] mdl [2][32];
    bit [31:0] seed = 32'hF34DD66F;
    int n_errors = 0;
    int num_checks = 0;

    pec_regs pec_regs_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .o_rdata(o_rdata),
        .o_rd_valid(o_rd_valid), .i_alarm_lvl(alm), .o_chan(o_chan), .o_hv_out_en(o_hv_out_en),
        .o_meas_route(o_meas_route), .o_meas_oe(o_meas_oe), .o_diff_cmp_en(o_diff_cmp_en),
        .o_dac_mon_en(o_dac_mon_en), .o_dac_mon_sel(o_dac_mon_sel), .o_pmu_alarm(o_pmu_alarm),
        .o_ovd_alarm(o_ovd_alarm));

    initial begin
        forever #5 i_clk = ~i_clk;
    end

    function automatic bit [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Channel 1 never stores the high-voltage bit
    function automatic logic [15:0] wmask(logic [4:0] a, int c);
        case (a)
            ADDR_PIN_ENABLE, ADDR_MEAS_OUT: return 16'h0007;
            ADDR_CH_STATE: return (c == 1) ? 16'h0003 : 16'h0007;
            ADDR_MEASURE_UNIT_STATE: return 16'h03BF;
            ADDR_DIFF_CMP: return 16'h0001;
            ADDR_DAC_MON, ADDR_ALM_MASK: return 16'h0003;
            default: return 16'h0000;
        endcase
    endfunction

    function automatic void mdl_wr(logic [1:0] ch, logic [4:0] a, logic [15:0] d);
        for (int c = 0; c < 2; c++) begin
            if (ch[c]) begin
                mdl[(a inside {[ADDR_MEAS_OUT:ADDR_DAC_MON]}) ? 0 : c][a] = d & wmask(a, c);
            end
        end
    endfunction

    function automatic logic [15:0] exp_rd(logic [1:0] ch, logic [4:0] a);
        int c = ch[0] ? 0 : 1;
        if (ch == 2'b00) return 16'h0000;
        if (a == ADDR_ALM_STATE) return {13'h0000, alm[c]};
        if (a inside {[ADDR_MEAS_OUT:ADDR_DAC_MON]}) c = 0;
        return mdl[c][a];
    endfunction

    function automatic pec_chan_ctrl_s exp_chan(int c);
        pec_chan_ctrl_s e;
        logic [15:0] ps = mdl[c][ADDR_MEASURE_UNIT_STATE];
        logic on = mdl[c][ADDR_PIN_ENABLE][PIN_ENABLE_CONTROL];
        e.drv_disable = mdl[c][ADDR_PIN_ENABLE][PE_DRV_DISABLE];
        e.force_term = mdl[c][ADDR_PIN_ENABLE][PE_FORCE_TERM];
        e.load_en = mdl[c][ADDR_CH_STATE][CS_LOAD_EN];
        e.drv_term_mode = mdl[c][ADDR_CH_STATE][CS_DRV_TERM];
        e.pmu_force_en = on;
        e.pmu_clamp_en = on & ps[5];
        e.pmu_force_i = on & ps[3];
        e.pmu_meas_i = on & ps[4];
        e.pmu_sense_ext = ps[7];
        e.pmu_src = !on ? PEC_SRC_GND : ps[9] ? PEC_SRC_DAC : pec_src_e'(ps[9:8]);
        e.pmu_range = (!on || !ps[2]) ? PEC_RANGE_E : pec_range_e'(ps[1:0] + 3'h1);
        return e;
    endfunction

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr(logic [1:0] ch, logic [4:0] a, logic [15:0] d);
        @(negedge i_clk);
        req = '{wr: 1'b1, rd: 1'b0, ch_sel: ch, addr: a, wdata: d};
        @(negedge i_clk);
        req.wr = 1'b0;
        mdl_wr(ch, a, d);
    endtask

    task automatic rd(logic [1:0] ch, logic [4:0] a);
        @(negedge i_clk);
        req = '{wr: 1'b0, rd: 1'b1, ch_sel: ch, addr: a, wdata: 16'h0000};
        @(negedge i_clk);
        req.rd = 1'b0;
        check("read valid", 16'h0001, {15'h0000, o_rd_valid});
        check("read data", exp_rd(ch, a), o_rdata);
    endtask

    task automatic chk_outs();
        logic [15:0] sh_exp;
        logic [15:0] sh_got;
        @(negedge i_clk);
        for (int c = 0; c < 2; c++) begin
            check("chan", 16'(exp_chan(c)), 16'(o_chan[c]));
            check("alarms", {14'h0000, mdl[c][ADDR_ALM_MASK][1] & alm[c].clamp,
                mdl[c][ADDR_ALM_MASK][0] & (alm[c].ovd_hi | alm[c].ovd_lo)},
                {14'h0000, o_pmu_alarm[c], o_ovd_alarm[c]});
        end
        sh_exp = {9'h000, mdl[0][ADDR_MEAS_OUT][2:0], mdl[0][ADDR_DIFF_CMP][0],
            mdl[0][ADDR_DAC_MON][1:0], mdl[0][ADDR_CH_STATE][2]};
        sh_got = {9'h000, o_meas_route, o_meas_oe, o_diff_cmp_en, o_dac_mon_en, o_dac_mon_sel,
            o_hv_out_en};
        check("shared ctrl", sh_exp, sh_got);
    endtask

    initial begin
        mdl = '{default: '{default: 16'h0000}};
        mdl[0][ADDR_ALM_MASK] = 16'h0001;
        mdl[1][ADDR_ALM_MASK] = 16'h0001;
        repeat (4) @(negedge i_clk);
        i_rst_n = 1'b1;
        // Reset values, the read-only state and unmapped places
        for (int a = 12; a < 22; a++) begin
            rd(2'b01, 5'(a));
        end
        chk_outs();
        wr(2'b10, ADDR_CH_STATE, 16'h0007);
        rd(2'b01, ADDR_CH_STATE);
        wr(2'b00, ADDR_MEAS_OUT, 16'hFFFF);
        wr(2'b11, ADDR_ALM_STATE, 16'hFFFF);
        wr(2'b11, ADDR_MEASURE_UNIT_STATE, 16'hFFFF);
        chk_outs();
        rd(2'b11, ADDR_MEASURE_UNIT_STATE);
        for (int i = 0; i < 300; i++) begin
            alm = 6'(rnd());
            repeat (3) @(negedge i_clk);
            rch = 2'(rnd());
            radr = 5'(12 + rnd() % 10);
            wr(rch, radr, 16'(rnd()));
            chk_outs();
            rd(rch, radr);
            rd(2'(rnd()), radr);
        end
        stop_test();
    end

    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
endmodule
